// ---- verilog/lane_steer_pkg.sv ----
// Shared types and constants for the external bus byte-lane steering block
package lane_steer_pkg;

    // Sequencer state
    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_BUSY = 1'b1
    } state_e;

    // Access size requested by the load/store path
    typedef enum logic [1:0] {
        SZ_BYTE = 2'b00,
        SZ_HALF = 2'b01,
        SZ_WORD = 2'b10
    } size_e;

    // Strobe style of the addressed area
    typedef enum logic [1:0] {
        IF_WR       = 2'b00,
        IF_2CAS_1WE = 2'b01,
        IF_1CAS_2WE = 2'b10
    } iface_e;

    localparam logic [2:0]  AREA_CODE_RST = 3'h0;
    localparam logic [2:0]  AREA_CODE_MAX = 3'h5;
    localparam logic [2:0]  AREA_NONE     = 3'h0;
    localparam logic [1:0]  LANES_NONE    = 2'h0;
    localparam logic [1:0]  LANE_UPPER    = 2'h1;
    localparam logic [1:0]  LANE_NEXT     = 2'h2;
    localparam logic [31:0] ADDR_RST      = 32'h0000_0000;
    localparam logic [31:0] WORD_RST      = 32'h0000_0000;
    localparam logic [15:0] HALF_RST      = 16'h0000;

endpackage : lane_steer_pkg

// ---- verilog/ext_bus_lane_steer.sv ----
// Byte-lane steering and strobe selection for narrow external buses
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - Selected area little endian, all others big
// - 16-bit: upper lane lane0, next lane1 strobes
// - 8-bit: only upper lane, single strobes
// - Word access starts output A1/A0 at 00
// - Half access starts output A1/A0 at 00 or 10
// - Address sequence same for both endians
// - Little endian word reverses all four bytes
// - Little endian half swaps its two bytes
// - Byte accesses never swap
// - Lane strobes independent of endianness
// - 16-bit word splits at offsets 0, 2
// - 8-bit word splits into four ascending bytes
// - Codes 1-5 pick area; 0 none; area 0 big
// - Area select accepts one write per reset
// - 16-bit byte: even upper lane, odd next
module ext_bus_lane_steer
    import lane_steer_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    // Endian area select setting
    input  wire logic        area_sel_wr,
    input  wire logic [2:0]  area_sel_code,
    output logic      [2:0]  area_sel_q,
    // Internal access request
    input  wire logic        req_valid,
    output logic             req_ready,
    input  wire logic        req_write,
    input  wire logic [1:0]  req_size,
    input  wire logic [31:0] req_addr,
    input  wire logic [2:0]  req_area,
    input  wire logic        req_bus8,
    input  wire logic [1:0]  req_iface,
    input  wire logic [31:0] req_wdata,
    // Access completion
    output logic             rsp_valid,
    output logic      [31:0] rsp_rdata,
    // External bus cycle
    output logic             ext_valid,
    input  wire logic        ext_ready,
    output logic             ext_write,
    output logic      [31:0] ext_addr,
    output logic      [15:0] ext_wdata,
    input  wire logic [15:0] ext_rdata,
    // Lane strobes, active low
    output logic             lane0_write_strobe_n,
    output logic             lane1_write_strobe_n,
    output logic             lower_column_strobe_n,
    output logic             upper_column_strobe_n,
    output logic             lower_write_enable_n,
    output logic             upper_write_enable_n
);

    typedef struct packed {
        state_e      st;
        logic        le;
        logic        wr;
        logic        w8;
        logic [1:0]  ift;
        logic [1:0]  size;
        logic [31:0] start;
        logic [1:0]  beat;
        logic [1:0]  last;
        logic [31:0] wdata;
        logic [31:0] rdata;
        logic [2:0]  code;
        logic        locked;
        logic [31:0] addr;
        logic [15:0] data;
        logic [1:0]  lanes;
        logic [3:0]  ridx;
        logic        done;
    } steer_s;

    logic       rst_meta_q, rst_sync_n;
    steer_s     s_q;
    steer_s     s_d;

    // Reset release synchroniser
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_n <= rst_meta_q;
        end
    end

    logic        accept, load, step, c_le, c_w8;
    logic [1:0]  c_size, nb, off, ri;
    logic [2:0]  nbytes;
    logic [31:0] c_start, c_wdata, ba, bya;

    assign req_ready = (s_q.st == ST_IDLE);
    assign accept    = req_valid && req_ready;
    assign step      = (s_q.st == ST_BUSY) && ext_ready;

    always_comb begin
        s_d       = s_q;
        s_d.done  = 1'b0;
        load      = 1'b0;
        c_le      = s_q.le;
        c_w8      = s_q.w8;
        c_size    = s_q.size;
        c_start   = s_q.start;
        c_wdata   = s_q.wdata;
        nb        = s_q.beat + 2'd1;
        nbytes    = 3'd0;
        ba        = ADDR_RST;
        bya       = ADDR_RST;
        off       = 2'd0;
        ri        = 2'd0;

        // One write to the area select, then locked until reset
        if (area_sel_wr && !s_q.locked) begin
            s_d.code   = area_sel_code;
            s_d.locked = 1'b1;
        end

        // Collect read bytes back into register order
        if (step && !s_q.wr) begin
            for (int l = 0; l < 2; l++) begin
                if (s_q.lanes[l]) begin
                    s_d.rdata[s_q.ridx[l*2 +: 2]*8 +: 8] = ext_rdata[(1-l)*8 +: 8];
                end
            end
        end

        case (s_q.st)
            ST_IDLE: begin
                if (accept) begin
                    load      = 1'b1;
                    nb        = 2'd0;
                    c_w8      = req_bus8;
                    c_size    = req_size;
                    c_wdata   = req_wdata;
                    // Area 0 and codes above 5 never select little endian
                    c_le      = (req_area != AREA_NONE) && (req_area == s_q.code)
                                && (s_q.code <= AREA_CODE_MAX);
                    case (req_size)
                        SZ_WORD: c_start = {req_addr[31:2], 2'b00};
                        SZ_HALF: c_start = {req_addr[31:1], 1'b0};
                        default: c_start = req_addr;
                    endcase
                    s_d.st    = ST_BUSY;
                    s_d.le    = c_le;
                    s_d.wr    = req_write;
                    s_d.w8    = c_w8;
                    s_d.ift   = req_iface;
                    s_d.size  = c_size;
                    s_d.start = c_start;
                    s_d.wdata = c_wdata;
                    s_d.rdata = WORD_RST;
                end
            end
            ST_BUSY: begin
                if (step) begin
                    if (s_q.beat == s_q.last) begin
                        s_d.st    = ST_IDLE;
                        s_d.done  = 1'b1;
                        s_d.lanes = LANES_NONE;
                    end else begin
                        load = 1'b1;
                    end
                end
            end
            default: s_d.st = ST_IDLE;
        endcase

        if (load) begin
            nbytes = 3'd1 << c_size;
            // Beat count and stride depend only on width and size
            if (c_w8) begin
                s_d.last = 2'(nbytes - 3'd1);
                ba       = c_start + {30'h0, nb};
            end else begin
                s_d.last = (c_size == SZ_WORD) ? 2'd1 : 2'd0;
                ba       = c_start + {29'h0, nb, 1'b0};
            end
            s_d.beat  = nb;
            s_d.addr  = ba;
            s_d.data  = HALF_RST;
            s_d.lanes = LANES_NONE;
            s_d.ridx  = 4'h0;
            for (int l = 0; l < 2; l++) begin
                bya = c_w8 ? ba : {ba[31:1], l[0]};
                off = bya[1:0] - c_start[1:0];
                // Lanes outside the access stay dark; 8-bit uses upper lane only
                if (({1'b0, off} < nbytes) && (!c_w8 || l == 0)) begin
                    ri = c_le ? off : 2'(nbytes - 3'd1 - {1'b0, off});
                    s_d.lanes[l]          = 1'b1;
                    s_d.ridx[l*2 +: 2]    = ri;
                    s_d.data[(1-l)*8 +: 8] = c_wdata[ri*8 +: 8];
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            s_q <= '{st: ST_IDLE, code: AREA_CODE_RST, lanes: LANES_NONE, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    logic busy;
    assign busy       = (s_q.st == ST_BUSY);
    assign area_sel_q = s_q.code;
    assign rsp_valid  = s_q.done;
    assign rsp_rdata  = s_q.rdata;
    assign ext_valid  = busy;
    assign ext_write  = s_q.wr;
    assign ext_addr   = s_q.addr;
    assign ext_wdata  = s_q.data;

    // Strobes follow lanes, interface type and write direction, never endianness
    always_comb begin
        lane0_write_strobe_n  = 1'b1;
        lane1_write_strobe_n  = 1'b1;
        lower_column_strobe_n = 1'b1;
        upper_column_strobe_n = 1'b1;
        lower_write_enable_n  = 1'b1;
        upper_write_enable_n  = 1'b1;
        if (busy) begin
            case (s_q.ift)
                IF_WR: begin
                    lane0_write_strobe_n = !(s_q.wr && s_q.lanes[0]);
                    lane1_write_strobe_n = !(s_q.wr && s_q.lanes[1]);
                end
                IF_2CAS_1WE: begin
                    lower_column_strobe_n = !s_q.lanes[0];
                    upper_column_strobe_n = !s_q.lanes[1];
                    lower_write_enable_n  = !s_q.wr;
                end
                IF_1CAS_2WE: begin
                    lower_column_strobe_n = !(|s_q.lanes);
                    lower_write_enable_n  = !(s_q.wr && s_q.lanes[0]);
                    upper_write_enable_n  = !(s_q.wr && s_q.lanes[1]);
                end
                default: lane0_write_strobe_n = 1'b1;
            endcase
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_sync_n);

    a_word_addr_zero: assert property (accept && req_size == SZ_WORD |=> ext_addr[1:0] == 2'b00)
        else $error("word access low address not 00");
    a_half_addr_pair: assert property (accept && req_size == SZ_HALF
        |=> ext_addr[1:0] == {$past(req_addr[1]), 1'b0})
        else $error("half access low address wrong");
    a_area0_big: assert property (accept && req_area == AREA_NONE |=> !s_q.le)
        else $error("area 0 treated as little endian");
    a_select_locked: assert property (s_q.locked |=> $stable(area_sel_q))
        else $error("area select changed after first write");
    a_narrow_upper: assert property (busy && s_q.w8 |-> !s_q.lanes[1] && lane1_write_strobe_n
        && upper_column_strobe_n && upper_write_enable_n)
        else $error("upper lane used on 8-bit bus");
    a_idle_dark: assert property (!busy |-> lane0_write_strobe_n && lane1_write_strobe_n
        && lower_column_strobe_n && lower_write_enable_n)
        else $error("strobe active with no access");
    a_le_word_swap: assert property (accept && req_size == SZ_WORD && !req_bus8 && c_le
        |=> ext_wdata == {$past(req_wdata[7:0]), $past(req_wdata[15:8])})
        else $error("little endian word first beat not reversed");
    a_le_half_swap: assert property (accept && req_size == SZ_HALF && !req_bus8 && c_le
        |=> ext_wdata == {$past(req_wdata[7:0]), $past(req_wdata[15:8])})
        else $error("little endian half not swapped");
    a_byte_no_swap: assert property (accept && req_size == SZ_BYTE && !req_bus8
        |=> ($past(req_addr[0]) ? ext_wdata[7:0] : ext_wdata[15:8]) == $past(req_wdata[7:0]))
        else $error("byte data placed wrong");
    a_byte_odd_lane: assert property (accept && req_size == SZ_BYTE && !req_bus8 && req_addr[0]
        |=> s_q.lanes == LANE_NEXT)
        else $error("odd byte not on next lane");
    a_word16_second: assert property (step && !s_q.w8 && s_q.size == SZ_WORD && s_q.beat == 2'd0
        |=> busy && ext_addr == $past(ext_addr) + 32'd2 && s_q.lanes == 2'b11)
        else $error("16-bit word second half wrong");
    a_bus8_ascend: assert property (step && s_q.w8 && s_q.beat != s_q.last
        |=> ext_addr == $past(ext_addr) + 32'd1)
        else $error("8-bit beats not ascending by one");
    a_wr_lane0: assert property (busy && s_q.ift == IF_WR && s_q.wr
        |-> lane0_write_strobe_n == !s_q.lanes[0])
        else $error("lane0 write strobe mismatch");

    c_le_word8: cover property (accept && req_size == SZ_WORD && req_bus8 && c_le);
    c_half16: cover property (accept && req_size == SZ_HALF && !req_bus8);
    c_byte_odd: cover property (accept && req_size == SZ_BYTE && req_addr[0] && !req_bus8);
    c_sel_lock: cover property (s_q.locked && area_sel_wr);

endmodule : ext_bus_lane_steer
`default_nettype wire

// ---- dv/ext_mem_model.sv ----
// Behavioural external memory wired to both data lanes, upper lane only on an 8-bit bus
`timescale 1ns/1ns
`default_nettype none
module ext_mem_model
    import lane_steer_pkg::*;
(
    // Clock
    input  wire logic        sys_clk,
    // Bus beat
    input  wire logic        ext_valid,
    output logic             ext_ready,
    input  wire logic        ext_write,
    input  wire logic [31:0] ext_addr,
    input  wire logic [15:0] ext_wdata,
    output logic      [15:0] ext_rdata,
    // Width, strobe style and strobes
    input  wire logic        bus8,
    input  wire logic [1:0]  iface,
    input  wire logic [5:0]  stb_n,
    // Answer delay in cycles
    input  wire logic [1:0]  wait_cyc
);
    logic [7:0]  mem [16];
    logic [31:0] beat_q [$];
    logic [1:0]  cnt = 2'h0;
    logic        en0;
    logic        en1;
    logic [3:0]  a;
    // stb_n: lane0, lane1, lower col, upper col, lower we, upper we
    assign a   = ext_addr[3:0];
    assign en0 = (iface == IF_WR) ? !stb_n[5] : (iface == IF_2CAS_1WE) ? !stb_n[3] : !stb_n[1];
    assign en1 = (iface == IF_WR) ? !stb_n[4] : (iface == IF_2CAS_1WE) ? !stb_n[2] : !stb_n[0];
    assign ext_ready = ext_valid && (cnt == wait_cyc);
    // Unused lower lane shows a changing pattern, not the last value
    assign ext_rdata = bus8 ? {mem[a], ~mem[a]} : {mem[{a[3:1], 1'b0}], mem[{a[3:1], 1'b1}]};
    always @(posedge sys_clk) begin
        cnt <= (ext_valid && !ext_ready) ? cnt + 2'h1 : 2'h0;
        if (ext_valid && ext_ready) begin
            beat_q.push_back(ext_addr);
            if (ext_write && en0) mem[bus8 ? a : {a[3:1], 1'b0}] <= ext_wdata[15:8];
            if (ext_write && en1 && !bus8) mem[{a[3:1], 1'b1}] <= ext_wdata[7:0];
        end
    end
endmodule : ext_mem_model
`default_nettype wire

// ---- dv/tb_ext_bus_endian_lane_steering.sv ----
// Self-checking bench for the byte-lane steering block
`timescale 1ns/1ns
`default_nettype none
module tb_ext_bus_endian_lane_steering;
    import lane_steer_pkg::*;
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        area_sel_wr = 1'b0;
    logic [2:0]  area_sel_code = 3'h0;
    logic [2:0]  area_sel_q;
    logic        req_valid = 1'b0;
    logic        req_ready;
    logic        req_write = 1'b0;
    logic [1:0]  req_size = 2'h0;
    logic [31:0] req_addr = 32'h0;
    logic [2:0]  req_area = 3'h0;
    logic        req_bus8 = 1'b0;
    logic [1:0]  req_iface = 2'h0;
    logic [31:0] req_wdata = 32'h0;
    logic        rsp_valid;
    logic [31:0] rsp_rdata;
    logic        ext_valid;
    logic        ext_ready;
    logic        ext_write;
    logic [31:0] ext_addr;
    logic [15:0] ext_wdata;
    logic [15:0] ext_rdata;
    logic        lane0_write_strobe_n;
    logic        lane1_write_strobe_n;
    logic        lower_column_strobe_n;
    logic        upper_column_strobe_n;
    logic        lower_write_enable_n;
    logic        upper_write_enable_n;
    logic [5:0]  stb_n;
    logic [1:0]  wait_cyc = 2'h0;
    logic [31:0] rd;
    int          err_total = 0;
    int          samples_checked = 0;
    assign stb_n = {lane0_write_strobe_n, lane1_write_strobe_n, lower_column_strobe_n,
                    upper_column_strobe_n, lower_write_enable_n, upper_write_enable_n};
    ext_bus_lane_steer u_dut (.sys_clk, .rst_n, .area_sel_wr, .area_sel_code, .area_sel_q,
        .req_valid, .req_ready, .req_write, .req_size, .req_addr, .req_area, .req_bus8,
        .req_iface, .req_wdata, .rsp_valid, .rsp_rdata, .ext_valid, .ext_ready, .ext_write,
        .ext_addr, .ext_wdata, .ext_rdata, .lane0_write_strobe_n, .lane1_write_strobe_n,
        .lower_column_strobe_n, .upper_column_strobe_n, .lower_write_enable_n,
        .upper_write_enable_n);
    ext_mem_model u_mem (.sys_clk, .ext_valid, .ext_ready, .ext_write, .ext_addr, .ext_wdata,
        .ext_rdata, .bus8(req_bus8), .iface(req_iface), .stb_n, .wait_cyc);
    always #5 sys_clk = ~sys_clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic beats(input logic [31:0] b0, input int n, input int st);
        chk(u_mem.beat_q.size(), n);
        for (int i = 0; i < n && i < u_mem.beat_q.size(); i++) chk(u_mem.beat_q[i], b0 + i * st);
    endtask : beats
    function automatic logic [31:0] mw(input int o);
        return {u_mem.mem[o], u_mem.mem[o + 1], u_mem.mem[o + 2], u_mem.mem[o + 3]};
    endfunction : mw
    task automatic acc(input logic wr, input logic [1:0] sz, input logic [31:0] ad,
                       input logic [2:0] ar, input logic b8, input logic [1:0] ifc,
                       input logic [31:0] wd, input logic [1:0] wt);
        int n;
        u_mem.beat_q.delete();
        wait_cyc  <= wt;
        req_valid <= 1'b1;
        req_write <= wr;
        req_size  <= sz;
        req_addr  <= ad;
        req_area  <= ar;
        req_bus8  <= b8;
        req_iface <= ifc;
        req_wdata <= wd;
        @(posedge sys_clk);
        for (n = 0; n < 40 && req_ready !== 1'b1; n++) @(posedge sys_clk);
        req_valid <= 1'b0;
        @(posedge sys_clk);
        for (n = 0; n < 40 && rsp_valid !== 1'b1; n++) @(posedge sys_clk);
        chk(rsp_valid, 1'b1);
        rd = rsp_rdata;
    endtask : acc
    task automatic test_done;
        $display("checks %0d, mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : test_done
    // Idle lanes and narrow-bus upper strobes must stay high
    always @(negedge sys_clk) begin
        if (rst_n && ((!ext_valid && stb_n !== 6'h3F) || (req_bus8 && ext_valid
            && {stb_n[4], stb_n[2], stb_n[0]} !== 3'h7))) begin
            err_total++;
            $display("wrong value at %0t: strobe active on idle lane", $time);
        end
    end
    initial begin
        repeat (4000) @(posedge sys_clk);
        err_total++;
        test_done;
    end
    initial begin
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk({area_sel_q, stb_n, req_ready}, 10'h07F);
        area_sel_wr   <= 1'b1;
        area_sel_code <= 3'h3;
        @(posedge sys_clk);
        area_sel_code <= 3'h5;
        @(posedge sys_clk);
        area_sel_wr   <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk(area_sel_q, 3'h3);
        acc(1'b1, SZ_WORD, 32'h3, 3'h0, 1'b0, IF_WR, 32'hAABBCCDD, 2'h2);
        beats(32'h0, 2, 2);
        chk(mw(0), 32'hAABBCCDD);
        acc(1'b1, SZ_WORD, 32'h6, 3'h3, 1'b0, IF_2CAS_1WE, 32'h11223344, 2'h0);
        beats(32'h4, 2, 2);
        chk(mw(4), 32'h44332211);
        acc(1'b0, SZ_WORD, 32'h4, 3'h2, 1'b0, IF_2CAS_1WE, 32'h0, 2'h1);
        chk(rd, 32'h44332211);
        acc(1'b1, SZ_WORD, 32'h9, 3'h3, 1'b1, IF_1CAS_2WE, 32'h55667788, 2'h1);
        beats(32'h8, 4, 1);
        chk(mw(8), 32'h88776655);
        acc(1'b0, SZ_WORD, 32'h8, 3'h1, 1'b1, IF_WR, 32'h0, 2'h0);
        chk(rd, 32'h88776655);
        acc(1'b1, SZ_HALF, 32'hF, 3'h3, 1'b0, IF_WR, 32'hA1B2, 2'h0);
        beats(32'hE, 1, 2);
        chk({u_mem.mem[14], u_mem.mem[15]}, 16'hB2A1);
        acc(1'b0, SZ_HALF, 32'hF, 3'h0, 1'b0, IF_WR, 32'h0, 2'h0);
        chk(rd, 32'h0000B2A1);
        acc(1'b0, SZ_HALF, 32'hF, 3'h3, 1'b1, IF_2CAS_1WE, 32'h0, 2'h2);
        beats(32'hE, 2, 1);
        chk(rd, 32'h0000A1B2);
        acc(1'b1, SZ_BYTE, 32'h5, 3'h3, 1'b0, IF_WR, 32'hC3, 2'h0);
        acc(1'b1, SZ_BYTE, 32'h6, 3'h0, 1'b0, IF_1CAS_2WE, 32'h5A, 2'h0);
        chk(mw(4), 32'h44C35A11);
        acc(1'b0, SZ_BYTE, 32'h5, 3'h3, 1'b1, IF_2CAS_1WE, 32'h0, 2'h0);
        chk(rd, 32'hC3);
        acc(1'b0, SZ_BYTE, 32'h5, 3'h3, 1'b0, IF_WR, 32'h0, 2'h0);
        chk(rd, 32'hC3);
        test_done;
    end
endmodule : tb_ext_bus_endian_lane_steering
`default_nettype wire
